// ==== bench/gff_host.sv ====
// partner: host side of the two pins, resolving the wire level
`timescale 1ns/1ps
module gff_host (
	input  wire logic       clk,
	input  wire logic [1:0] pin_out,
	input  wire logic [1:0] pin_oe,
	input  wire logic [1:0] pin_pull_up,
	input  wire logic [1:0] pin_pull_down,
	input  wire logic [1:0] host_lvl,
	input  wire logic [1:0] host_en,
	output logic      [1:0] pin_in
);
	logic [1:0] churn = 2'h1;

	// a floating pin wanders, so no stale level can pass for a real one
	always @(posedge clk)
		churn <= ~churn;

	always_comb
		for (int i = 0; i < 2; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : host_en[i] ? host_lvl[i] :
				pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 : churn[i];
endmodule

// ==== bench/gff_monitor_asserts.sv ====
// checker: port-level assertions for the pin function and fault monitor
`timescale 1ns/1ps
module gff_monitor_asserts #(
	parameter int TX_DOM_CYC = gff_pkg::TX_DOM_CYC
)(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [1:0]       pin_in,
	input  wire logic [1:0]       pin_out,
	input  wire logic             txd_in,
	input  gff_pkg::gff_can_mode_e can_mode,
	input  wire logic             vio_fault_in,
	input  wire logic             bus_dominant_drive,
	input  wire logic             rst_pin_oe,
	input  wire logic             wake_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [23:0] txl_r, txl_nxt, aul_r, aul_nxt;
	logic [7:0]  vq_r, vq_nxt, bh_r, bh_nxt;
	logic [4:0]  since_r, since_nxt;
	logic        pout_r;

	// saturating, so long idle spells never wrap back into range
	always_comb
	begin
		txl_nxt = txd_in ? 24'h0 : txl_r + {23'h0, ~&txl_r};
		aul_nxt = pin_in[1] ? 24'h0 : aul_r + {23'h0, ~&aul_r};
		vq_nxt = vio_fault_in ? 8'h00 : vq_r + {7'h0, ~&vq_r};
		bh_nxt = !(txd_in && pin_in[1]) ? 8'h00 : bh_r + {7'h0, ~&bh_r};
		since_nxt = (pin_out[0] != pout_r) ? 5'h00 : since_r + {4'h0, ~&since_r};
	end

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			txl_r <= 24'h0;
			aul_r <= 24'h0;
			vq_r <= 8'h00;
			bh_r <= 8'h00;
			since_r <= 5'h1f;
			pout_r <= 1'b0;
		end
		else
		begin
			txl_r <= txl_nxt;
			aul_r <= aul_nxt;
			vq_r <= vq_nxt;
			bh_r <= bh_nxt;
			since_r <= since_nxt;
			pout_r <= pin_out[0];
		end

	sequence vio_held;
		vio_fault_in [*8];
	endsequence

	chk_vio_assert: assert property (vio_held |-> rst_pin_oe)
		else $error("reset pin not pulled for vio fault");
	chk_vio_hold: assert property ($fell(rst_pin_oe) |-> vq_r >= 8'd100)
		else $error("reset pin released too early");
	chk_vio_release: assert property (rst_pin_oe |-> vq_r <= 8'd110)
		else $error("reset pin held too long");
	chk_tx_release: assert property (bus_dominant_drive |->
		(txl_r <= TX_DOM_CYC + 8 || aul_r <= TX_DOM_CYC + 8))
		else $error("bus held dominant past timeout");
	chk_dom_cause: assert property (bus_dominant_drive |-> bh_r < 8'd8)
		else $error("dominant with both transmit inputs high");
	chk_drive_mode: assert property
		((can_mode != gff_pkg::CAN_NORMAL) [*3] |-> !bus_dominant_drive)
		else $error("transmitter drives outside normal mode");
	chk_min_pulse: assert property ((pin_out[0] != pout_r) |-> since_r >= 5'd19)
		else $error("pin one pulse shorter than minimum");
	chk_wake_pulse: assert property (wake_request |=> !wake_request)
		else $error("wake request longer than one cycle");
endmodule

// ==== bench/test_gff_monitor.sv ====
// testbench: directed scenarios for the pin function and fault monitor
`timescale 1ns/1ps
module test_gff_monitor;
	logic                   clk = 0;
	logic                   rst_n = 0;
	logic [7:0]             reg_addr = 8'h00;
	logic [31:0]            reg_wdata = 32'h0, reg_rdata;
	logic                   reg_wr = 0, reg_rd = 0;
	logic [1:0]             pin_in, pin_out, pin_oe, pin_pu, pin_pd;
	logic [1:0]             host_lvl = 2'h0, host_en = 2'h3;
	logic                   txd_in = 1, bus_rx = 1, vcc_low = 0, vio = 0;
	gff_pkg::gff_can_mode_e can_mode = gff_pkg::CAN_NORMAL;
	gff_pkg::gff_stat_in_s  stat = '0;
	logic                   bus_dom, rxd_out, rst_pin_oe, wake_req;
	int                     bad_count = 0, compares = 0;

	always #5 clk = ~clk;

	gff_monitor #(.TX_DOM_CYC(40), .BUS_DOM_CYC(40), .UV_DET_CYC(20)) dut (
		.clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pull_up(pin_pu), .pin_pull_down(pin_pd),
		.txd_in(txd_in), .bus_rx_in(bus_rx), .can_mode(can_mode),
		.vcc_below_in(vcc_low), .vio_fault_in(vio), .stat_in(stat),
		.bus_dominant_drive(bus_dom), .rxd_out(rxd_out),
		.rst_pin_oe(rst_pin_oe), .wake_request(wake_req));

	gff_host host (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull_up(pin_pu), .pin_pull_down(pin_pd), .host_lvl(host_lvl),
		.host_en(host_en), .pin_in(pin_in));

	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1;
		check(reg_rdata & m, e);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic t_regs();
		for (int a = 0; a <= 32; a += 4)
			rd(a[7:0], 32'hffffffff, 32'h0);
	endtask

	task automatic t_input();
		@(posedge clk) host_lvl[0] <= 1;
		cyc(120);
		rd(8'h14, 32'h1, 32'h1);
		wr(8'h00, 32'h100);
		cyc(3);
		check(pin_pu[0], 1);
	endtask

	task automatic t_output();
		@(posedge clk) host_en[0] <= 0;
		wr(8'h00, 32'h1001);
		cyc(3);
		check({pin_oe[0], pin_out[0]}, 2'b11);
		wr(8'h00, 32'h0001);
		cyc(10);
		check(pin_out[0], 1);
		cyc(20);
		check(pin_out[0], 0);
	endtask

	task automatic t_txdis();
		wr(8'h04, 32'h2);
		@(posedge clk) txd_in <= 0;
		cyc(8);
		check(bus_dom, 1);
		@(posedge clk) host_lvl[1] <= 1;
		cyc(8);
		check(bus_dom, 0);
		@(posedge clk) txd_in <= 1;
		cyc(120);
		rd(8'h14, 32'h2, 32'h2);
		@(posedge clk) host_lvl[1] <= 0;
	endtask

	task automatic t_clamp();
		wr(8'h0c, 32'h1);
		@(posedge clk) txd_in <= 0;
		cyc(60);
		check(bus_dom, 0);
		rd(8'h14, 32'h4, 32'h4);
		rd(8'h10, 32'h1, 32'h1);
		@(posedge clk) txd_in <= 1;
		cyc(8);
		wr(8'h10, 32'h1);
		rd(8'h10, 32'h1, 32'h0);
	endtask

	task automatic t_vio();
		@(posedge clk) vio <= 1;
		cyc(10);
		check(rst_pin_oe, 1);
		@(posedge clk) vio <= 0;
		cyc(60);
		check(rst_pin_oe, 1);
		cyc(60);
		check(rst_pin_oe, 0);
	endtask

	task automatic t_bus();
		wr(8'h0c, 32'h4);
		wr(8'h08, 32'h4);
		@(posedge clk) can_mode <= gff_pkg::CAN_LISTEN;
		@(posedge clk) bus_rx <= 0;
		cyc(60);
		rd(8'h14, 32'h10, 32'h0);
		check(rxd_out, 0);
		wr(8'h08, 32'h0);
		cyc(60);
		rd(8'h14, 32'h10, 32'h10);
		rd(8'h10, 32'h4, 32'h4);
		@(posedge clk) bus_rx <= 1;
		@(posedge clk) can_mode <= gff_pkg::CAN_NORMAL;
	endtask

	task automatic t_vcc();
		wr(8'h00, 32'h1006);
		wr(8'h0c, 32'h8);
		@(posedge clk) vcc_low <= 1;
		cyc(40);
		check(pin_out[0], 1);
		rd(8'h14, 32'h20, 32'h20);
		rd(8'h10, 32'h8, 32'h8);
		@(posedge clk) vcc_low <= 0;
	endtask

	task automatic t_aux_rx();
		wr(8'h00, 32'h4);
		wr(8'h08, 32'h1);
		@(posedge clk) bus_rx <= 0;
		cyc(8);
		check({rxd_out, pin_out[0]}, 2'b10);
		@(posedge clk) bus_rx <= 1;
	endtask

	task automatic t_wake();
		int seen = 0;
		wr(8'h0c, 32'h10);
		wr(8'h04, 32'h10010);
		wr(8'h00, 32'h1003);
		@(posedge clk) host_lvl[1] <= 1;
		repeat (130)
		begin
			@(posedge clk);
			#1;
			seen += wake_req;
		end
		check(seen, 1);
		check(pin_out[0], 1);
		rd(8'h10, 32'h10, 32'h10);
		@(posedge clk) stat.wake_pattern <= 1;
		wr(8'h00, 32'h0009);
		cyc(3);
		check(pin_out[0], 0);
	endtask

	initial
	begin
		#100000;
		bad_count++;
		print_verdict();
	end

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		t_regs();
		t_input();
		t_output();
		t_txdis();
		t_clamp();
		t_vio();
		t_bus();
		t_vcc();
		t_aux_rx();
		t_wake();
		print_verdict();
	end
endmodule

bind gff_monitor gff_monitor_asserts #(.TX_DOM_CYC(TX_DOM_CYC)) u_chk (
	.clk(clk), .rst_n(rst_n), .pin_in(pin_in), .pin_out(pin_out),
	.txd_in(txd_in), .can_mode(can_mode), .vio_fault_in(vio_fault_in),
	.bus_dominant_drive(bus_dominant_drive), .rst_pin_oe(rst_pin_oe),
	.wake_request(wake_request));

// ==== hdl/gff_monitor.sv ====
// pin function routing, input filters, dominant timeouts and supply monitors
`timescale 1ns/1ps
module gff_monitor #(
	parameter int TX_DOM_CYC  = gff_pkg::TX_DOM_CYC,
	parameter int BUS_DOM_CYC = gff_pkg::BUS_DOM_CYC,
	parameter int UV_DET_CYC  = gff_pkg::UV_DET_CYC
)(
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	input  wire logic [gff_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]                reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [31:0]                reg_rdata,
	input  wire logic [1:0]                 pin_in,
	output logic      [1:0]                 pin_out,
	output logic      [1:0]                 pin_oe,
	output logic      [1:0]                 pin_pull_up,
	output logic      [1:0]                 pin_pull_down,
	input  wire logic                       txd_in,
	input  wire logic                       bus_rx_in,
	input  gff_pkg::gff_can_mode_e          can_mode,
	input  wire logic                       vcc_below_in,
	input  wire logic                       vio_fault_in,
	input  gff_pkg::gff_stat_in_s           stat_in,
	output logic                            bus_dominant_drive,
	output logic                            rxd_out,
	output logic                            rst_pin_oe,
	output logic                            wake_request
);

	localparam int TW = gff_pkg::TIMER_W;
	localparam int FW = gff_pkg::FLT_W;
	localparam int HW = gff_pkg::HLD_W;
	localparam int RW = gff_pkg::REL_W;
	localparam int NT = 4;
	localparam int TM_TX = 0;
	localparam int TM_AUX = 1;
	localparam int TM_BUS = 2;
	localparam int TM_UV = 3;
	localparam logic [FW-1:0] FLT_LAST = FW'(gff_pkg::FILTER_CYC - 1);
	localparam logic [HW-1:0] HLD_LAST = HW'(gff_pkg::MIN_PULSE_CYC - 1);
	localparam logic [RW-1:0] REL_LAST = RW'(gff_pkg::RST_REL_CYC - 1);

	function automatic logic [31:0] cfg_word(input gff_pkg::gff_pin_cfg_s c);
		logic [31:0] w;
		w = '0;
		w[gff_pkg::PCFG_FUNC_LSB +: 5] = c.func;
		w[gff_pkg::PCFG_DRV_LSB +: 3] = c.drv;
		w[gff_pkg::PCFG_POL_BIT] = c.pol;
		w[gff_pkg::PCFG_WRISE_BIT] = c.wake_rise;
		w[gff_pkg::PCFG_WFALL_BIT] = c.wake_fall;
		return w;
	endfunction

	function automatic gff_pkg::gff_pin_cfg_s cfg_from(input logic [31:0] w);
		gff_pkg::gff_pin_cfg_s c;
		c.func = gff_pkg::gff_func_e'(w[gff_pkg::PCFG_FUNC_LSB +: 5]);
		c.drv = w[gff_pkg::PCFG_DRV_LSB +: 3];
		c.pol = w[gff_pkg::PCFG_POL_BIT];
		c.wake_rise = w[gff_pkg::PCFG_WRISE_BIT];
		c.wake_fall = w[gff_pkg::PCFG_WFALL_BIT];
		return c;
	endfunction

	// saturating counter that restarts whenever its level goes inactive
	function automatic logic [TW-1:0] tstep(input logic [TW-1:0] c, input logic act,
		input logic [TW-1:0] lim);
		if (!act)
			return '0;
		else if (c >= lim)
			return lim;
		else
			return c + TW'(1);
	endfunction

	// input synchronisers: a change counts once stages two and three agree
	logic [gff_pkg::SYNC_N-1:0] sy1_r, sy2_r, sy3_r, syl_r, syl_nxt;
	logic [gff_pkg::SYNC_N-1:0] async_in;

	assign async_in = {vio_fault_in, vcc_below_in, bus_rx_in, txd_in, pin_in};

	always_comb
	begin
		syl_nxt = (sy2_r & sy3_r) | (syl_r & (sy2_r | sy3_r));
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sy1_r <= gff_pkg::SYNC_RST;
			sy2_r <= gff_pkg::SYNC_RST;
			sy3_r <= gff_pkg::SYNC_RST;
			syl_r <= gff_pkg::SYNC_RST;
		end
		else if (ce)
		begin
			sy1_r <= async_in;
			sy2_r <= sy1_r;
			sy3_r <= sy2_r;
			syl_r <= syl_nxt;
		end
	end

	logic [1:0] pin_s;
	logic       txd_s, bus_rx_s, vcc_low_s, vio_bad_s;

	assign pin_s = syl_r[1:0];
	assign txd_s = syl_r[2];
	assign bus_rx_s = syl_r[3];
	assign vcc_low_s = syl_r[4];
	assign vio_bad_s = syl_r[5];

	// software registers
	gff_pkg::gff_pin_cfg_s [1:0]  cfg_r, cfg_nxt;
	logic [gff_pkg::CTRL_W-1:0]   ctrl_r, ctrl_nxt;
	logic [gff_pkg::EV_N-1:0]     irq_en_r, irq_en_nxt, flag_r, flag_nxt;
	logic [gff_pkg::EV_N-1:0]     ev, w1c;
	logic [31:0]                  rdata_nxt, status_word;

	// timeout monitors
	logic [NT-1:0][TW-1:0] tmr_r, tmr_nxt, tmr_lim;
	logic [NT-1:0]         tmr_act, done, done_nxt;
	logic                  aux_tx_en, bus_mon_en, irq_pend;

	assign tmr_lim[TM_TX] = TW'(TX_DOM_CYC);
	assign tmr_lim[TM_AUX] = TW'(TX_DOM_CYC);
	assign tmr_lim[TM_BUS] = TW'(BUS_DOM_CYC);
	assign tmr_lim[TM_UV] = TW'(UV_DET_CYC);
	assign aux_tx_en = cfg_r[1].func == gff_pkg::FN_AUX_TX;
	assign bus_mon_en = can_mode == gff_pkg::CAN_NORMAL
		|| (can_mode == gff_pkg::CAN_LISTEN && !ctrl_r[gff_pkg::CTRL_LOW_PWR]);
	assign irq_pend = |(flag_r & irq_en_r) | stat_in.irq_ext;

	always_comb
	begin
		tmr_act[TM_TX] = !txd_s;
		tmr_act[TM_AUX] = aux_tx_en && !pin_s[1];
		tmr_act[TM_BUS] = bus_mon_en && !bus_rx_s;
		tmr_act[TM_UV] = vcc_low_s;
		for (int k = 0; k < NT; k++)
		begin
			tmr_nxt[k] = tstep(tmr_r[k], tmr_act[k], tmr_lim[k]);
			done[k] = tmr_r[k] == tmr_lim[k];
			done_nxt[k] = tmr_nxt[k] == tmr_lim[k];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tmr_r <= '0;
		else if (ce)
			tmr_r <= tmr_nxt;
	end

	// pin filters, function routing and drivers
	logic [1:0][FW-1:0] fcnt_r, fcnt_nxt;
	logic [1:0][HW-1:0] hold_r, hold_nxt;
	logic [1:0]         lvl_r, lvl_nxt, val_r, val_nxt, wake_ev;
	logic [1:0]         pout_nxt, poe_nxt, ppu_nxt, ppd_nxt;
	logic               tx_dis, is_out, act, want;

	always_comb
	begin
		tx_dis = 1'b0;
		is_out = 1'b0;
		act = 1'b0;
		want = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			// level filter, independent of function
			fcnt_nxt[i] = '0;
			lvl_nxt[i] = lvl_r[i];
			if (pin_s[i] != lvl_r[i])
			begin
				if (fcnt_r[i] == FLT_LAST)
					lvl_nxt[i] = pin_s[i];
				else
					fcnt_nxt[i] = fcnt_r[i] + FW'(1);
			end
			wake_ev[i] = cfg_r[i].func == gff_pkg::FN_LOCAL_WAKE && lvl_nxt[i] != lvl_r[i]
				&& (lvl_nxt[i] ? cfg_r[i].wake_rise : cfg_r[i].wake_fall);
			// raw synced level so the disable acts without the filter delay
			if (cfg_r[i].func == gff_pkg::FN_TX_DISABLE && pin_s[i])
				tx_dis = 1'b1;
			is_out = 1'b1;
			act = 1'b0;
			case (cfg_r[i].func)
				gff_pkg::FN_OUTPUT:       act = 1'b1;
				gff_pkg::FN_IRQ:          act = irq_pend;
				gff_pkg::FN_AUX_RX:       is_out = i == 0;
				gff_pkg::FN_VCC_LOW:      act = done[TM_UV];
				gff_pkg::FN_TX_CLAMP:     act = done[TM_TX];
				gff_pkg::FN_AUX_TX_CLAMP:
				begin
					act = done[TM_AUX];
					is_out = i == 0;
				end
				gff_pkg::FN_WAKE_PATTERN: act = stat_in.wake_pattern;
				gff_pkg::FN_WAKE_FRAME:   act = stat_in.wake_frame;
				gff_pkg::FN_BIAS:         act = stat_in.bias_active;
				gff_pkg::FN_WAKE_RISE:    act = stat_in.wake_rise;
				gff_pkg::FN_WAKE_FALL:    act = stat_in.wake_fall;
				gff_pkg::FN_CAN_ACTIVE:   act = stat_in.can_ready;
				gff_pkg::FN_LISTEN:       act = can_mode == gff_pkg::CAN_LISTEN;
				gff_pkg::FN_INHIBIT:      act = stat_in.inhibit;
				default:                  is_out = 1'b0;
			endcase
			// bus data is forwarded as is, status functions honour polarity
			if (cfg_r[i].func == gff_pkg::FN_AUX_RX)
				want = bus_rx_s;
			else
				want = cfg_r[i].pol ? act : !act;
			// a change is held back until the last level has stood long enough
			hold_nxt[i] = hold_r[i] == HLD_LAST ? hold_r[i] : hold_r[i] + HW'(1);
			val_nxt[i] = val_r[i];
			if (want != val_r[i] && hold_r[i] == HLD_LAST)
			begin
				val_nxt[i] = want;
				hold_nxt[i] = '0;
			end
			pout_nxt[i] = 1'b0;
			poe_nxt[i] = 1'b0;
			ppu_nxt[i] = 1'b0;
			ppd_nxt[i] = 1'b0;
			if (is_out)
			begin
				case (cfg_r[i].drv)
					gff_pkg::OUT_PUSH_PULL:
					begin
						pout_nxt[i] = val_nxt[i];
						poe_nxt[i] = 1'b1;
					end
					gff_pkg::OUT_HS_OD:
					begin
						pout_nxt[i] = 1'b1;
						poe_nxt[i] = val_nxt[i];
					end
					gff_pkg::OUT_HS_WPD:
					begin
						pout_nxt[i] = 1'b1;
						poe_nxt[i] = val_nxt[i];
						ppd_nxt[i] = 1'b1;
					end
					gff_pkg::OUT_LS_OD:
						poe_nxt[i] = !val_nxt[i];
					gff_pkg::OUT_LS_WPU:
					begin
						poe_nxt[i] = !val_nxt[i];
						ppu_nxt[i] = 1'b1;
					end
					default:
					begin
						pout_nxt[i] = val_nxt[i];
						poe_nxt[i] = 1'b1;
					end
				endcase
			end
			else
			begin
				// repeater keeps the line at its last filtered level
				ppu_nxt[i] = cfg_r[i].drv == gff_pkg::IN_PULL_UP
					|| (cfg_r[i].drv == gff_pkg::IN_REPEATER && lvl_r[i]);
				ppd_nxt[i] = cfg_r[i].drv == gff_pkg::IN_PULL_DOWN
					|| (cfg_r[i].drv == gff_pkg::IN_REPEATER && !lvl_r[i]);
			end
			// a config change also moves the pin, so it restarts the minimum width too
			if (pout_nxt[i] != pin_out[i] || poe_nxt[i] != pin_oe[i])
				hold_nxt[i] = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fcnt_r <= '0;
			lvl_r <= 2'h0;
			hold_r <= '0;
			val_r <= 2'h0;
			pin_out <= 2'h0;
			pin_oe <= 2'h0;
			pin_pull_up <= 2'h0;
			pin_pull_down <= 2'h0;
		end
		else if (ce)
		begin
			fcnt_r <= fcnt_nxt;
			lvl_r <= lvl_nxt;
			hold_r <= hold_nxt;
			val_r <= val_nxt;
			pin_out <= pout_nxt;
			pin_oe <= poe_nxt;
			pin_pull_up <= ppu_nxt;
			pin_pull_down <= ppd_nxt;
		end
	end

	// transmit path and receive output
	logic p_dom, a_dom, drive_nxt, rxd_nxt, aux_rx_only;

	always_comb
	begin
		p_dom = !txd_s && !done[TM_TX];
		a_dom = aux_tx_en && !pin_s[1] && !done[TM_AUX];
		if (aux_tx_en && ctrl_r[gff_pkg::CTRL_AUX_TX_EXCL])
			drive_nxt = a_dom;
		else
			drive_nxt = p_dom || a_dom;
		drive_nxt = drive_nxt && !tx_dis && can_mode == gff_pkg::CAN_NORMAL;
		aux_rx_only = ctrl_r[gff_pkg::CTRL_AUX_RX_ONLY] && cfg_r[0].func == gff_pkg::FN_AUX_RX;
		if (aux_rx_only && (can_mode == gff_pkg::CAN_NORMAL || can_mode == gff_pkg::CAN_LISTEN))
			rxd_nxt = 1'b1;
		else
			rxd_nxt = bus_rx_s;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_dominant_drive <= 1'b0;
			rxd_out <= 1'b1;
		end
		else if (ce)
		begin
			bus_dominant_drive <= drive_nxt;
			rxd_out <= rxd_nxt;
		end
	end

	// supply fault reset sequencing
	gff_pkg::gff_rst_state_e rs_r, rs_nxt;
	logic [RW-1:0]           rel_r, rel_nxt;

	always_comb
	begin
		rs_nxt = rs_r;
		rel_nxt = '0;
		case (rs_r)
			gff_pkg::RS_RUN:
				if (vio_bad_s)
					rs_nxt = gff_pkg::RS_HOLD;
			gff_pkg::RS_HOLD:
				if (!vio_bad_s)
					rs_nxt = gff_pkg::RS_RELEASE;
			gff_pkg::RS_RELEASE:
				if (vio_bad_s)
					rs_nxt = gff_pkg::RS_HOLD;
				else if (rel_r == REL_LAST)
					rs_nxt = gff_pkg::RS_RUN;
				else
					rel_nxt = rel_r + RW'(1);
			default:
				rs_nxt = gff_pkg::RS_HOLD;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs_r <= gff_pkg::RS_RUN;
			rel_r <= '0;
			rst_pin_oe <= 1'b0;
		end
		else if (ce)
		begin
			rs_r <= rs_nxt;
			rel_r <= rel_nxt;
			rst_pin_oe <= rs_nxt != gff_pkg::RS_RUN;
		end
	end

	// register access, events and flags
	always_comb
	begin
		ev = '0;
		ev[gff_pkg::EV_TX_CLAMP] = done_nxt[TM_TX] && !done[TM_TX];
		ev[gff_pkg::EV_AUX_CLAMP] = done_nxt[TM_AUX] && !done[TM_AUX];
		ev[gff_pkg::EV_BUS_STUCK] = done_nxt[TM_BUS] && !done[TM_BUS];
		ev[gff_pkg::EV_VCC_LOW] = done_nxt[TM_UV] && !done[TM_UV];
		ev[gff_pkg::EV_LOCAL_WAKE] = |wake_ev;
		w1c = '0;
		if (reg_wr && reg_addr == gff_pkg::OFS_FLAGS)
			w1c = reg_wdata[gff_pkg::EV_N-1:0];
		flag_nxt = (flag_r & ~w1c) | (ev & irq_en_r);
		cfg_nxt = cfg_r;
		ctrl_nxt = ctrl_r;
		irq_en_nxt = irq_en_r;
		if (reg_wr)
		begin
			case (reg_addr)
				gff_pkg::OFS_PIN1_CFG: cfg_nxt[0] = cfg_from(reg_wdata);
				gff_pkg::OFS_PIN2_CFG: cfg_nxt[1] = cfg_from(reg_wdata);
				gff_pkg::OFS_CTRL:     ctrl_nxt = reg_wdata[gff_pkg::CTRL_W-1:0];
				gff_pkg::OFS_IRQ_EN:   irq_en_nxt = reg_wdata[gff_pkg::EV_N-1:0];
				default:               ctrl_nxt = ctrl_r;
			endcase
		end
		status_word = '0;
		status_word[gff_pkg::ST_PIN_ONE] = lvl_r[0];
		status_word[gff_pkg::ST_PIN_TWO] = lvl_r[1];
		status_word[gff_pkg::ST_TX_CLAMP] = done[TM_TX];
		status_word[gff_pkg::ST_AUX_CLAMP] = done[TM_AUX];
		status_word[gff_pkg::ST_BUS_STUCK] = done[TM_BUS];
		status_word[gff_pkg::ST_VCC_LOW] = done[TM_UV];
		status_word[gff_pkg::ST_VIO_RESET] = rs_r != gff_pkg::RS_RUN;
		rdata_nxt = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				gff_pkg::OFS_PIN1_CFG: rdata_nxt = cfg_word(cfg_r[0]);
				gff_pkg::OFS_PIN2_CFG: rdata_nxt = cfg_word(cfg_r[1]);
				gff_pkg::OFS_CTRL:     rdata_nxt = {29'h0, ctrl_r};
				gff_pkg::OFS_IRQ_EN:   rdata_nxt = {27'h0, irq_en_r};
				gff_pkg::OFS_FLAGS:    rdata_nxt = {27'h0, flag_r};
				gff_pkg::OFS_STATUS:   rdata_nxt = status_word;
				default:               rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_r <= '0;
			ctrl_r <= gff_pkg::CTRL_RST;
			irq_en_r <= gff_pkg::IRQ_EN_RST;
			flag_r <= gff_pkg::FLAG_RST;
			reg_rdata <= 32'h0;
			wake_request <= 1'b0;
		end
		else if (ce)
		begin
			cfg_r <= cfg_nxt;
			ctrl_r <= ctrl_nxt;
			irq_en_r <= irq_en_nxt;
			flag_r <= flag_nxt;
			reg_rdata <= rdata_nxt;
			wake_request <= ev[gff_pkg::EV_LOCAL_WAKE];
		end
	end

endmodule

// ==== include/gff_pkg.sv ====
// package: constants, register map and types for the pin function and fault monitor
package gff_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int FILTER_NS      = 1000;
	localparam int MIN_PULSE_NS   = 200;
	localparam int TX_DOM_NS      = 2500000;
	localparam int BUS_DOM_NS     = 2500000;
	localparam int UV_DET_NS      = 100000;
	localparam int RST_RELEASE_NS = 1000;
	localparam int FILTER_CYC     = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_PULSE_CYC  = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TX_DOM_CYC     = (TX_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUS_DOM_CYC    = (BUS_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UV_DET_CYC     = (UV_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_REL_CYC    = (RST_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// counter widths
	localparam int TIMER_W = 24;
	localparam int FLT_W   = $clog2(FILTER_CYC + 1);
	localparam int HLD_W   = $clog2(MIN_PULSE_CYC + 1);
	localparam int REL_W   = $clog2(RST_REL_CYC + 1);

	// register offsets
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] OFS_PIN1_CFG = 8'h00;
	localparam logic [7:0] OFS_PIN2_CFG = 8'h04;
	localparam logic [7:0] OFS_CTRL     = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h0c;
	localparam logic [7:0] OFS_FLAGS    = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;

	// pin configuration fields
	localparam int PCFG_FUNC_LSB  = 0;
	localparam int PCFG_DRV_LSB   = 8;
	localparam int PCFG_POL_BIT   = 12;
	localparam int PCFG_WRISE_BIT = 16;
	localparam int PCFG_WFALL_BIT = 17;

	// control fields
	localparam int CTRL_W           = 3;
	localparam int CTRL_AUX_RX_ONLY = 0;
	localparam int CTRL_AUX_TX_EXCL = 1;
	localparam int CTRL_LOW_PWR     = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

	// event bits, shared by irq enable and flag registers
	localparam int EV_N          = 5;
	localparam int EV_TX_CLAMP   = 0;
	localparam int EV_AUX_CLAMP  = 1;
	localparam int EV_BUS_STUCK  = 2;
	localparam int EV_VCC_LOW    = 3;
	localparam int EV_LOCAL_WAKE = 4;
	localparam logic [EV_N-1:0] IRQ_EN_RST = 5'h00;
	localparam logic [EV_N-1:0] FLAG_RST   = 5'h00;

	// status fields
	localparam int ST_PIN_ONE   = 0;
	localparam int ST_PIN_TWO   = 1;
	localparam int ST_TX_CLAMP  = 2;
	localparam int ST_AUX_CLAMP = 3;
	localparam int ST_BUS_STUCK = 4;
	localparam int ST_VCC_LOW   = 5;
	localparam int ST_VIO_RESET = 6;

	// synchroniser order: pin1, pin2, txd, bus rx, vcc low, vio fault
	localparam int            SYNC_N   = 6;
	localparam logic [5:0]    SYNC_RST = 6'h0c;

	// input behaviours and output drivers share the drive field
	localparam logic [2:0] IN_FLOAT      = 3'h0;
	localparam logic [2:0] IN_PULL_UP    = 3'h1;
	localparam logic [2:0] IN_PULL_DOWN  = 3'h2;
	localparam logic [2:0] IN_REPEATER   = 3'h3;
	localparam logic [2:0] OUT_PUSH_PULL = 3'h0;
	localparam logic [2:0] OUT_HS_OD     = 3'h1;
	localparam logic [2:0] OUT_HS_WPD    = 3'h2;
	localparam logic [2:0] OUT_LS_OD     = 3'h3;
	localparam logic [2:0] OUT_LS_WPU    = 3'h4;

	typedef enum logic [4:0] {
		FN_INPUT        = 5'h00,
		FN_OUTPUT       = 5'h01,
		FN_TX_DISABLE   = 5'h02,
		FN_IRQ          = 5'h03,
		FN_AUX_RX       = 5'h04,
		FN_AUX_TX       = 5'h05,
		FN_VCC_LOW      = 5'h06,
		FN_TX_CLAMP     = 5'h07,
		FN_AUX_TX_CLAMP = 5'h08,
		FN_WAKE_PATTERN = 5'h09,
		FN_WAKE_FRAME   = 5'h0a,
		FN_BIAS         = 5'h0b,
		FN_WAKE_RISE    = 5'h0c,
		FN_WAKE_FALL    = 5'h0d,
		FN_CAN_ACTIVE   = 5'h0e,
		FN_LISTEN       = 5'h0f,
		FN_LOCAL_WAKE   = 5'h10,
		FN_INHIBIT      = 5'h11
	} gff_func_e;

	typedef enum logic [1:0] {
		CAN_OFF    = 2'h0,
		CAN_NORMAL = 2'h1,
		CAN_LISTEN = 2'h2
	} gff_can_mode_e;

	typedef enum logic [1:0] {
		RS_RUN     = 2'h0,
		RS_HOLD    = 2'h1,
		RS_RELEASE = 2'h3
	} gff_rst_state_e;

	typedef struct packed {
		logic      wake_fall;
		logic      wake_rise;
		logic      pol;
		logic [2:0] drv;
		gff_func_e func;
	} gff_pin_cfg_s;

	typedef struct packed {
		logic wake_pattern;
		logic wake_frame;
		logic bias_active;
		logic wake_rise;
		logic wake_fall;
		logic can_ready;
		logic inhibit;
		logic irq_ext;
	} gff_stat_in_s;

endpackage
